/* busy_length_rom.sv */
// Registered busy length lookup by instruction scenario.
`timescale 1ns/1ps
`default_nettype none
`include "busy_reset_defines.svh"
module busy_length_rom
  import busy_reset_pkg::*;
(
  // Clock.
  input  wire logic       clk,
  // Scenario.
  input  wire logic [2:0] sel,
  // Length.
  output logic      [7:0] len_r
);
  logic [7:0] table_r [0:7];
  always_comb begin
    table_r[0] = `BUSY_SHORT_EDGES;
    table_r[1] = `BUSY_DAC1_EDGES;
    table_r[2] = `BUSY_DAC2_EDGES;
    table_r[3] = `BUSY_DAC1_CAL_EDGES;
    table_r[4] = `BUSY_DAC2_CAL_EDGES;
    table_r[5] = `RESET_CLOCKED_EDGES;
    table_r[6] = `BUSY_SHORT_EDGES;
    table_r[7] = `BUSY_SHORT_EDGES;
  end
  always_ff @(posedge clk) begin
    len_r <= table_r[sel];
  end
endmodule // busy_length_rom
`default_nettype wire

/* busy_reset_chk.sv */
// Assertion checker for the busy and reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module busy_reset_chk (
  // Clock and pins.
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       rst_pin_n,
  input wire logic       instr_valid,
  // Outputs watched.
  input wire logic       busy_o,
  input wire logic       busy_oe,
  input wire logic       regs_default,
  input wire logic       levels_to_ground,
  input wire logic       units_disable,
  input wire logic       switches_open,
  input wire logic       pins_soft_ground,
  input wire logic       dac_defaults_load,
  input wire logic       thermal_alarm_en,
  input wire logic [7:0] thermal_thresh_c,
  input wire logic       measure_alarm_en,
  input wire logic       overvoltage_alarm_en
);
  logic [3:0] age_r;
  logic       sclk_q_r;
  // Cycles since the last serial clock rise, saturating.
  always_ff @(posedge clk) begin
    sclk_q_r <= sclk;
    age_r    <= (srst || (sclk && !sclk_q_r)) ? 4'h0 :
                age_r + {3'h0, age_r != 4'hF};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  od_data_a: assert property (busy_o == 1'b0)
    else $error("busy data not low");
  cmd_busy_a: assert property ($rose(cs_n) && instr_valid |->
    ##[1:6] busy_oe) else $error("busy missing after instruction");
  pin_busy_a: assert property (!rst_pin_n [*6] |-> busy_oe)
    else $error("busy not held by reset pin");
  safe_state_a: assert property (!rst_pin_n [*6] |->
    regs_default && levels_to_ground && units_disable && switches_open &&
    pins_soft_ground) else $error("reset state not safe");
  edge_rel_a: assert property ($fell(busy_oe) |-> age_r <= 4'h6)
    else $error("busy released away from a clock rise");
  thresh_a: assert property (thermal_alarm_en |->
    thermal_thresh_c == 8'h64) else $error("thermal threshold wrong");
  alarms_a: assert property (thermal_alarm_en |->
    !measure_alarm_en && !overvoltage_alarm_en) else $error("alarms on");
  load_pulse_a: assert property (dac_defaults_load |=>
    !dac_defaults_load) else $error("default load not a pulse");
  load_busy_a: assert property (dac_defaults_load |-> busy_oe [*8])
    else $error("busy dropped in clocked phase");
  cover property ($fell(busy_oe));
  cover property (dac_defaults_load);
  cover property ($rose(cs_n) && instr_valid);
endmodule // busy_reset_chk
`default_nettype wire

/* busy_reset_defines.svh */
// Timing counts and field positions for the busy and reset sequencer.
`ifndef BUSY_RESET_DEFINES_SVH
`define BUSY_RESET_DEFINES_SVH
`define BUSY_SHORT_EDGES    8'h03
`define BUSY_DAC1_EDGES     8'h0A
`define BUSY_DAC2_EDGES     8'h10
`define BUSY_DAC1_CAL_EDGES 8'h14
`define BUSY_DAC2_CAL_EDGES 8'h1A
`define RESET_CLOCKED_EDGES 8'h40
`define SOFT_ARM_EDGES      8'h02
`define DAC_ADDR_FIRST      7'h01
`define DAC_ADDR_LAST       7'h0E
`define SPI_CTRL_ADDR       7'h12
`define SPI_RESET_BIT       0
`define THERMAL_THRESH_C    8'h64
`define DEGLITCH_NS         3000
`define SETTLE_NS           10000
`define CLK_PERIOD_NS       4
`define DEGLITCH_CYCLES     ((`DEGLITCH_NS) / (`CLK_PERIOD_NS))
`define SETTLE_CYCLES       ((`SETTLE_NS) / (`CLK_PERIOD_NS))
`endif

/* busy_reset_pkg.sv */
// Types shared by the busy and reset sequencer.
package busy_reset_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RST_HOLD,
    ST_RST_ARM,
    ST_RST_CLOCKED,
    ST_BUSY_CMD
  } seq_state_t;
endpackage

/* busy_reset_sequencer.sv */
// Busy output and reset sequencer driven by serial clock edges.
`timescale 1ns/1ps
`default_nettype none
`include "busy_reset_defines.svh"
module busy_reset_sequencer
  import busy_reset_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Serial pins from the host.
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       rst_pin_n,
  // Decoded instruction, sampled at chip-select release.
  input  wire logic       instr_valid,
  input  wire logic       instr_write,
  input  wire logic [6:0] instr_addr,
  input  wire logic       instr_two_ch,
  input  wire logic [15:0] instr_data,
  input  wire logic       cal_enable,
  // Busy open-drain pin.
  output logic            busy_o,
  output logic            busy_oe,
  // Reset actions.
  output logic            regs_default,
  output logic            levels_to_ground,
  output logic            units_disable,
  output logic            switches_open,
  output logic            pins_soft_ground,
  output logic            spi_init_done,
  output logic            dac_defaults_load,
  output logic            thermal_alarm_en,
  output logic      [7:0] thermal_thresh_c,
  output logic            measure_alarm_en,
  output logic            overvoltage_alarm_en,
  output logic            deglitch_active,
  output logic            dac_settling
);
  logic [1:0] sclk_s, cs_s, rst_s;
  logic       sclk_d, cs_d;
  seq_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [2:0] sel;
  logic [7:0] len;
  logic       soft_req_r;
  logic       load_r;
  logic [13:0] dg_r;
  logic [13:0] st_r;

  function automatic logic is_dac(input logic [6:0] a);
    is_dac = (a >= `DAC_ADDR_FIRST) && (a <= `DAC_ADDR_LAST);
  endfunction

  wire sclk_rise = sclk_s[1] & ~sclk_d;
  wire cs_rel    = cs_s[1] & ~cs_d;
  wire rst_low   = ~rst_s[1];
  wire dac_wr    = instr_write & is_dac(instr_addr);
  wire soft_wr   = instr_valid & instr_write &
                   (instr_addr == `SPI_CTRL_ADDR) &
                   instr_data[`SPI_RESET_BIT];
  wire in_reset  = (state_r == ST_RST_HOLD) ||
                   (state_r == ST_RST_ARM) ||
                   (state_r == ST_RST_CLOCKED);

  // Scenario select for the length table.
  assign sel = !dac_wr ? 3'd0 :
               cal_enable ? (instr_two_ch ? 3'd4 : 3'd3) :
               (instr_two_ch ? 3'd2 : 3'd1);

  busy_length_rom u_rom (
    .clk   (clk),
    .sel   (sel),
    .len_r (len)
  );

  always_ff @(posedge clk) begin
    sclk_s <= {sclk_s[0], sclk};
    cs_s   <= {cs_s[0], cs_n};
    rst_s  <= {rst_s[0], rst_pin_n};
    sclk_d <= sclk_s[1];
    cs_d   <= cs_s[1];
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (cs_rel && soft_wr) begin
          state_nxt = ST_RST_ARM;
          cnt_nxt   = `SOFT_ARM_EDGES;
        end else if (cs_rel && instr_valid) begin
          state_nxt = ST_BUSY_CMD;
          cnt_nxt   = 8'd0;
        end
      end
      ST_BUSY_CMD: begin
        if (cnt_r == 8'd0) begin
          // An edge in the load cycle still counts, so busy never runs long.
          cnt_nxt = sclk_rise ? len - 8'd1 : len;
        end else if (sclk_rise) begin
          cnt_nxt = cnt_r - 8'd1;
          if (cnt_r == 8'd1) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_RST_HOLD: begin
        if (!rst_low && sclk_rise) begin
          state_nxt = ST_RST_CLOCKED;
          cnt_nxt   = `RESET_CLOCKED_EDGES - 8'd1;
        end
      end
      ST_RST_ARM: begin
        if (sclk_rise) begin
          cnt_nxt = cnt_r - 8'd1;
          if (cnt_r == 8'd1) begin
            state_nxt = ST_RST_CLOCKED;
            cnt_nxt   = `RESET_CLOCKED_EDGES - 8'd1;
          end
        end
      end
      ST_RST_CLOCKED: begin
        if (sclk_rise) begin
          cnt_nxt = cnt_r - 8'd1;
          if (cnt_r == 8'd1) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (rst_low) begin
      state_nxt = ST_RST_HOLD;
      cnt_nxt   = 8'd0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_RST_HOLD;
      cnt_r   <= 8'd0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  wire rst_end = (state_r == ST_RST_CLOCKED) && (state_nxt == ST_IDLE);
  wire rst_go  = (state_r != ST_RST_CLOCKED) &&
                 (state_nxt == ST_RST_CLOCKED);

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_o               <= 1'b0;
      busy_oe              <= 1'b1;
      regs_default         <= 1'b1;
      levels_to_ground     <= 1'b1;
      units_disable        <= 1'b1;
      switches_open        <= 1'b1;
      pins_soft_ground     <= 1'b1;
      spi_init_done        <= 1'b0;
      dac_defaults_load    <= 1'b0;
      thermal_alarm_en     <= 1'b0;
      thermal_thresh_c     <= 8'h00;
      measure_alarm_en     <= 1'b0;
      overvoltage_alarm_en <= 1'b0;
      deglitch_active      <= 1'b0;
      dac_settling         <= 1'b0;
      dg_r                 <= 14'd0;
      st_r                 <= 14'd0;
    end else begin
      busy_o  <= 1'b0;
      busy_oe <= (state_nxt != ST_IDLE);
      regs_default      <= in_reset || (state_nxt == ST_RST_HOLD) ||
                           (state_nxt == ST_RST_ARM);
      dac_defaults_load <= rst_go;
      if (rst_go) begin
        spi_init_done        <= 1'b1;
        thermal_alarm_en     <= 1'b1;
        thermal_thresh_c     <= `THERMAL_THRESH_C;
        measure_alarm_en     <= 1'b0;
        overvoltage_alarm_en <= 1'b0;
      end
      if (rst_end) begin
        deglitch_active <= 1'b1;
        dg_r            <= 14'(`DEGLITCH_CYCLES);
      end else if (deglitch_active) begin
        dg_r <= dg_r - 14'd1;
        if (dg_r == 14'd1) begin
          deglitch_active  <= 1'b0;
          levels_to_ground <= 1'b0;
          dac_settling     <= 1'b1;
          st_r             <= 14'(`SETTLE_CYCLES);
        end
      end else if (dac_settling) begin
        st_r <= st_r - 14'd1;
        if (st_r == 14'd1) begin
          dac_settling <= 1'b0;
        end
      end
      // The static reset state comes last so that it beats the deglitch end.
      if (state_nxt == ST_RST_HOLD || state_nxt == ST_RST_ARM) begin
        levels_to_ground <= 1'b1;
        units_disable    <= 1'b1;
        switches_open    <= 1'b1;
        pins_soft_ground <= 1'b1;
        spi_init_done    <= 1'b0;
        deglitch_active  <= 1'b0;
        dac_settling     <= 1'b0;
      end
    end
  end
endmodule // busy_reset_sequencer
`default_nettype wire

/* host_model.sv */
// Host-side serial clock source for the sequencer bench.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Control.
  input wire logic run,
  // Serial clock.
  output logic     sclk
);
  // Clock rests low between frames and runs while busy.
  initial sclk = 1'b0;
  always #24 sclk = run ? ~sclk : 1'b0;
endmodule // host_model
`default_nettype wire

/* tb_busy_reset_sequencer.sv */
// Self-checking bench for the busy and reset sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "busy_reset_defines.svh"
module tb_busy_reset_sequencer;
  logic        clk = 1'b0, srst = 1'b1, run = 1'b0, cs_n = 1'b1;
  logic        rst_pin_n = 1'b0, instr_valid = 1'b0, instr_write = 1'b0;
  logic        instr_two_ch = 1'b0, cal_enable = 1'b0;
  logic [6:0]  instr_addr = 7'h00;
  logic [15:0] instr_data = 16'h0000;
  logic        sclk, busy_o, busy_oe, regs_default, levels_to_ground;
  logic        units_disable, switches_open, pins_soft_ground;
  logic        spi_init_done, dac_defaults_load, thermal_alarm_en;
  logic        measure_alarm_en, overvoltage_alarm_en;
  logic        deglitch_active, dac_settling;
  logic [7:0]  thermal_thresh_c;
  int          fails = 0, checks = 0, cyc = 0;
  logic [7:0]  loads = 8'h00;
  logic [6:0]  ta [7] = '{7'h00, 7'h05, 7'h11, 7'h01, 7'h0E, 7'h05, 7'h01};
  logic [2:0]  tf [7] = '{3'b100, 3'b011, 3'b110, 3'b100, 3'b110, 3'b101,
                          3'b111};
  logic [7:0]  te [7] = '{`BUSY_SHORT_EDGES, `BUSY_SHORT_EDGES,
    `BUSY_SHORT_EDGES, `BUSY_DAC1_EDGES, `BUSY_DAC2_EDGES,
    `BUSY_DAC1_CAL_EDGES, `BUSY_DAC2_CAL_EDGES};
  busy_reset_sequencer busy_reset_sequencer_inst (.clk, .srst, .sclk, .cs_n,
    .rst_pin_n, .instr_valid, .instr_write, .instr_addr, .instr_two_ch,
    .instr_data, .cal_enable, .busy_o, .busy_oe, .regs_default,
    .levels_to_ground, .units_disable, .switches_open, .pins_soft_ground,
    .spi_init_done, .dac_defaults_load, .thermal_alarm_en,
    .thermal_thresh_c, .measure_alarm_en, .overvoltage_alarm_en,
    .deglitch_active, .dac_settling);
  host_model host_model_inst (.run, .sclk);
  always #2 clk = ~clk;
  // Counts default-load pulses where the pulse has settled.
  always @(negedge clk) if (dac_defaults_load === 1'b1) loads <= loads + 8'h01;
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Runs the serial clock and counts rises until busy lets go.
  task automatic count(string what, logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    run = 1'b1;
    while (busy_oe === 1'b1 && n < 8'hC8) begin
      @(posedge sclk);
      n++;
      tick(6);
    end
    run = 1'b0;
    chk(what, n, exp);
  endtask
  task automatic send(logic w, logic [6:0] a, logic t, logic c);
    {instr_write, instr_addr, instr_two_ch, cal_enable} = {w, a, t, c};
    instr_valid = 1'b1;
    cs_n = 1'b0;
    tick(4);
    cs_n = 1'b1;
    tick(8);
    chk("busy_oe", {7'h00, busy_oe}, 8'h01);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      final_report();
    end
  end
  initial begin
    tick(5);
    srst = 1'b0;
    tick(8);
    chk("regs_default", {7'h00, regs_default}, 8'h01);
    chk("pins_soft_ground", {7'h00, pins_soft_ground}, 8'h01);
    rst_pin_n = 1'b1;
    tick(40);
    chk("busy_hold", {7'h00, busy_oe}, 8'h01);
    count("reset_edges", `RESET_CLOCKED_EDGES);
    chk("thermal_thresh_c", thermal_thresh_c, 8'h64);
    chk("spi_init_done", {7'h00, spi_init_done}, 8'h01);
    chk("measure_alarm_en", {7'h00, measure_alarm_en}, 8'h00);
    chk("thermal_alarm_en", {7'h00, thermal_alarm_en}, 8'h01);
    chk("ovd_alarm_en", {7'h00, overvoltage_alarm_en}, 8'h00);
    chk("deglitch_active", {7'h00, deglitch_active}, 8'h01);
    tick(760);
    chk("deglitch_end", {7'h00, deglitch_active}, 8'h00);
    chk("dac_settling", {7'h00, dac_settling}, 8'h01);
    for (int i = 0; i < 7; i++) begin
      send(tf[i][2], ta[i], tf[i][1], tf[i][0]);
      count("busy_edges", te[i]);
    end
    send(1'b1, 7'h01, 1'b1, 1'b1);
    send(1'b1, 7'h00, 1'b0, 1'b0);
    count("busy_keep", `BUSY_DAC2_CAL_EDGES);
    instr_data = 16'h0001;
    send(1'b1, `SPI_CTRL_ADDR, 1'b0, 1'b0);
    instr_data = 16'h0000;
    count("soft_edges", `RESET_CLOCKED_EDGES + 8'h01);
    send(1'b1, 7'h01, 1'b1, 1'b1);
    count("dac_before_pin", `BUSY_DAC2_CAL_EDGES);
    tick(3300);
    chk("levels_released", {7'h00, levels_to_ground}, 8'h00);
    chk("regs_released", {7'h00, regs_default}, 8'h00);
    rst_pin_n = 1'b0;
    tick(8);
    chk("levels_to_ground", {7'h00, levels_to_ground}, 8'h01);
    chk("regs_default_pin", {7'h00, regs_default}, 8'h01);
    chk("units_disable", {7'h00, units_disable}, 8'h01);
    chk("switches_open", {7'h00, switches_open}, 8'h01);
    rst_pin_n = 1'b1;
    count("hard_edges", `RESET_CLOCKED_EDGES);
    tick(2);
    chk("default_loads", loads, 8'h03);
    final_report();
  end
endmodule // tb_busy_reset_sequencer
bind busy_reset_sequencer busy_reset_chk busy_reset_chk_inst (.clk, .srst,
  .sclk, .cs_n, .rst_pin_n, .instr_valid, .busy_o, .busy_oe, .regs_default,
  .levels_to_ground, .units_disable, .switches_open, .pins_soft_ground,
  .dac_defaults_load, .thermal_alarm_en, .thermal_thresh_c,
  .measure_alarm_en, .overvoltage_alarm_en);
`default_nettype wire
